// file: mcl_cfg.svh
// Purpose: named constants for the configuration word loader
// Assumes: included by bare name from every design file that needs it
// Notes: word indices, field positions and command codes of the serial link
// Functional notes
// (R1) customer ident is word 01 above word 00
// (R2) slave address is word 02 bits 6:0
// (R3) addresses 04..07 mean high-speed entry
// (R4) word 02 bit 9 sets select polarity
// (R5) codes 00/01: clock idles low, edge select
// (R6) codes 10/11: clock idles high, edge select
// (R7) offset: msb bit 0, sign bit 1
// (R8) gain: msb bit 2, sign bit 3
// (R9) gain temp first: msb 4, sign 5
// (R10) offset temp first: msb 6, sign 7
// (R11) offset temp second: msb 8, sign 9
// (R12) gain temp second: msb 10, sign 11
// (R13) writes 40..57, each word once per page
// (R14) spi only when interface select low
// (R15) load words 00..03 before serving commands
// (R16) ignore word 02 bits 8:7, 15:12
`ifndef MCL_CFG_SVH
`define MCL_CFG_SVH

`define MCL_W_ID_LO 0
`define MCL_W_ID_HI 1
`define MCL_W_IFCFG 2
`define MCL_W_COEF 3
`define MCL_WORD_LIMIT 8'h04
`define MCL_WORD_RST 16'h0000

`define MCL_ADDR_MSB 6
`define MCL_SSPOL_BIT 9
`define MCL_CPHA_BIT 10
`define MCL_CPOL_BIT 11
`define MCL_HS_LO 8'h04
`define MCL_HS_HI 8'h07
`define MCL_IFCFG_USED 16'h0E7F

`define MCL_CMD_WR_LO 8'h40
`define MCL_CMD_WR_HI 8'h57
`define MCL_CMD_RD_LO 8'h00
`define MCL_CMD_RD_HI 8'h17
`define MCL_CMD_PAGE_INC 8'h5E
`define MCL_PAGE_LAST 2'h3

`define MCL_FRAME_LAST 5'h17
`define MCL_FRAME_DONE 5'h18
`define MCL_ST_POWERED 6
`define MCL_ST_BUSY 5
`define MCL_ST_REJECT 1

`endif

// file: mcl_pkg.sv
// Purpose: shared types of the configuration word loader
// Assumes: nothing beyond the constants header
// Notes: loader states walk a gray sequence into run
package mcl_pkg;
  typedef logic [15:0] mcl_word_t;
  typedef logic [1:0] mcl_page_t;
  typedef enum logic [2:0] {
    MCL_LOAD0 = 3'h0,
    MCL_LOAD1 = 3'h1,
    MCL_LOAD2 = 3'h3,
    MCL_LOAD3 = 3'h2,
    MCL_RUN = 3'h6
  } mcl_state_t;
endpackage

// file: mcl_link_if.sv
// Purpose: signals between the control domain and the serial link logic
// Assumes: ctl side on sys_clk, link side on the serial clock
// Notes: all ctl outputs are quasi-static while a frame runs
`timescale 1ns/1ps
`default_nettype none
interface mcl_link_if;
  logic spi_en;
  logic ss_pol;
  logic smp_inv;
  logic [23:0] tx_word;
  logic [23:0] rx_word;
  logic rx_tgl;
  modport ctl (output spi_en, output ss_pol, output smp_inv, output tx_word,
               input rx_word, input rx_tgl);
  modport link (input spi_en, input ss_pol, input smp_inv, input tx_word,
                output rx_word, output rx_tgl);
endinterface
`default_nettype wire

// file: mcl_spi_link.sv
// Purpose: serial shifter on the link clock, three-byte frames
// Assumes: tx_word only changes between frames
// Notes: frame counters are cleared by the select going inactive
`timescale 1ns/1ps
`default_nettype none
`include "mcl_cfg.svh"
module mcl_spi_link
  import mcl_pkg::*;
(
  // link pins
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic spi_ss,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // control side
  mcl_link_if.link lk
);
  logic ss_act, frame_rst_n, smp_clk;
  logic [4:0] cnt_q, cnt_d, oc_q, oc_d;
  logic [23:0] sh_q, sh_d, rx_q, rx_d;
  logic tgl_q, tgl_d;

  assign ss_act = lk.spi_en & (lk.ss_pol ? spi_ss : ~spi_ss); // R4 R14
  assign frame_rst_n = rst_n & ss_act;
  // flipping the clock keeps one shifter for all four modes
  assign smp_clk = link_clk ^ lk.smp_inv; // R5 R6

  always_comb begin
    sh_d = {sh_q[22:0], spi_mosi};
    // parking one past the last bit keeps extra edges from handing over again
    cnt_d = (cnt_q == `MCL_FRAME_DONE) ? cnt_q : cnt_q + 5'h01;
    rx_d = rx_q;
    tgl_d = tgl_q;
    if (cnt_q == `MCL_FRAME_LAST) begin
      rx_d = {sh_q[22:0], spi_mosi};
      tgl_d = ~tgl_q;
    end
    // output index only moves once a bit has been taken, covering both phases
    oc_d = (cnt_q == 5'h00 || oc_q == `MCL_FRAME_LAST) ? oc_q : oc_q + 5'h01;
  end

  always_ff @(posedge smp_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q <= 5'h00;
      sh_q <= 24'h000000;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end

  always_ff @(posedge smp_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q <= 24'h000000;
      tgl_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      tgl_q <= tgl_d;
    end
  end

  always_ff @(negedge smp_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      oc_q <= 5'h00;
    end else begin
      oc_q <= oc_d;
    end
  end

  assign spi_miso = lk.tx_word[`MCL_FRAME_LAST - oc_q];
  assign spi_miso_oe = ss_act;
  assign lk.rx_word = rx_q;
  assign lk.rx_tgl = tgl_q;

  chk_frame_bound: assert property ( // R5
    @(posedge smp_clk) disable iff (!frame_rst_n) cnt_q <= `MCL_FRAME_DONE)
    else $error("frame bit counter ran past the last bit");
endmodule
`default_nettype wire

// file: mcl_config_loader.sv
// Purpose: holds and decodes configuration words 00..03 per page
// Assumes: i2c address events come from logic on sys_clk
// Notes: word storage is flops, cleared by reset in this model
`timescale 1ns/1ps
`default_nettype none
`include "mcl_cfg.svh"
module mcl_config_loader
  import mcl_pkg::*;
(
  // clocks and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // spi pins
  input wire logic spi_ss,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // interface select pin, high selects two-wire
  input wire logic if_sel,
  // two-wire address check
  input wire logic i2c_addr_vld,
  input wire logic [6:0] i2c_addr_rx,
  output logic i2c_addr_match,
  output logic i2c_hs_entry,
  // decoded configuration
  output logic cfg_ready,
  output logic [1:0] page_index,
  output logic [31:0] customer_ident,
  output logic [6:0] i2c_slave_addr,
  output logic spi_ss_active_high,
  output logic spi_clk_idle_high,
  output logic spi_sample_falling,
  output logic [5:0] coef_msb,
  output logic [5:0] coef_negative
);
  mcl_link_if lk ();

  mcl_spi_link u_link (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .spi_ss(spi_ss),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .lk(lk)
  );

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [7:0] mk_status(input logic busy, input logic rej);
    mk_status = 8'h00;
    mk_status[`MCL_ST_POWERED] = 1'b1;
    mk_status[`MCL_ST_BUSY] = busy;
    mk_status[`MCL_ST_REJECT] = rej;
  endfunction

  // synchronisers: select pin level and frame-done toggle
  logic sel_s1_q, sel_s2_q;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      sel_s1_q <= if_sel;
      sel_s2_q <= sel_s1_q;
      tgl_s1_q <= lk.rx_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  // rx_word changes on the same edge as its toggle and has settled once that toggle is synchronised, so it is safe to read here
  logic cmd_evt;
  logic [7:0] cmd, wr_idx;
  logic [15:0] cmd_data;
  logic is_wr, is_rd;
  assign cmd_evt = tgl_s2_q ^ tgl_s3_q;
  assign cmd = lk.rx_word[23:16];
  assign cmd_data = lk.rx_word[15:0];
  assign wr_idx = cmd - `MCL_CMD_WR_LO;
  assign is_wr = in_range(cmd, `MCL_CMD_WR_LO, `MCL_CMD_WR_HI); // R13
  assign is_rd = in_range(cmd, `MCL_CMD_RD_LO, `MCL_CMD_RD_HI);

  // word store, write-once flags, active words, loader
  mcl_word_t mem_q [4][4];
  mcl_word_t mem_d [4][4];
  logic [3:0] wr_q [4];
  logic [3:0] wr_d [4];
  mcl_word_t act_q [4];
  mcl_word_t act_d [4];
  mcl_page_t page_q, page_d;
  mcl_state_t st_q, st_d;
  logic rej_q, rej_d;
  logic [23:0] tx_q, tx_d;
  mcl_word_t rd_w;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    act_d = act_q;
    page_d = page_q;
    st_d = st_q;
    rej_d = rej_q;
    tx_d = tx_q;
    rd_w = `MCL_WORD_RST;
    case (st_q)
      MCL_LOAD0: begin
        act_d[0] = mem_q[page_q][0]; // R15
        st_d = MCL_LOAD1;
      end
      MCL_LOAD1: begin
        act_d[1] = mem_q[page_q][1];
        st_d = MCL_LOAD2;
      end
      MCL_LOAD2: begin
        act_d[2] = mem_q[page_q][2];
        st_d = MCL_LOAD3;
      end
      MCL_LOAD3: begin
        act_d[3] = mem_q[page_q][3];
        st_d = MCL_RUN;
      end
      MCL_RUN: begin
        if (cmd_evt) begin
          if (is_wr) begin
            // words above 03 belong to other logic and are passed over here
            if (wr_idx < `MCL_WORD_LIMIT) begin
              if (wr_q[page_q][wr_idx[1:0]]) begin
                rej_d = 1'b1; // R13
              end else begin
                mem_d[page_q][wr_idx[1:0]] = cmd_data;
                wr_d[page_q][wr_idx[1:0]] = 1'b1;
                act_d[wr_idx[1:0]] = cmd_data;
                rej_d = 1'b0;
              end
            end
          end else if (cmd == `MCL_CMD_PAGE_INC) begin
            if (page_q == `MCL_PAGE_LAST) begin
              rej_d = 1'b1;
            end else begin
              // a fresh page starts blank, so reload clears the active words
              page_d = page_q + 2'h1; // R13
              rej_d = 1'b0;
              st_d = MCL_LOAD0;
            end
          end else if (is_rd && cmd < `MCL_WORD_LIMIT) begin
            rd_w = mem_q[page_q][cmd[1:0]];
          end
          tx_d = {mk_status(st_d != MCL_RUN, rej_d), rd_w};
        end
      end
      default: st_d = MCL_LOAD0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < 4; p++) begin
        for (int w = 0; w < 4; w++) begin
          mem_q[p][w] <= `MCL_WORD_RST;
        end
        wr_q[p] <= 4'h0;
        act_q[p] <= `MCL_WORD_RST;
      end
      page_q <= 2'h0;
      st_q <= MCL_LOAD0;
      rej_q <= 1'b0;
      tx_q <= 24'h000000;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      act_q <= act_d;
      page_q <= page_d;
      st_q <= st_d;
      rej_q <= rej_d;
      tx_q <= tx_d;
    end
  end

  // two-wire address compare; high-speed codes never match as an address
  logic match_q, match_d, hs_q, hs_d, addr_hs;
  assign addr_hs = in_range({1'b0, i2c_addr_rx}, `MCL_HS_LO, `MCL_HS_HI);

  always_comb begin
    hs_d = 1'b0;
    match_d = 1'b0;
    if (i2c_addr_vld && sel_s2_q && cfg_ready) begin // R14
      hs_d = addr_hs; // R3
      match_d = !addr_hs && (i2c_addr_rx == i2c_slave_addr); // R2 R3
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      match_q <= match_d;
      hs_q <= hs_d;
    end
  end

  // decode of the active words; bits 8:7 and 15:12 of word 02 are never read
  assign cfg_ready = (st_q == MCL_RUN);
  assign page_index = page_q;
  assign customer_ident = {act_q[`MCL_W_ID_HI], act_q[`MCL_W_ID_LO]}; // R1
  assign i2c_slave_addr = act_q[`MCL_W_IFCFG][`MCL_ADDR_MSB:0]; // R2 R16
  assign spi_ss_active_high = act_q[`MCL_W_IFCFG][`MCL_SSPOL_BIT]; // R4
  assign spi_clk_idle_high = act_q[`MCL_W_IFCFG][`MCL_CPOL_BIT]; // R5 R6
  assign spi_sample_falling = act_q[`MCL_W_IFCFG][`MCL_CPOL_BIT]
                            ^ act_q[`MCL_W_IFCFG][`MCL_CPHA_BIT]; // R5 R6
  for (genvar k = 0; k < 6; k++) begin : g_coef
    assign coef_msb[k] = act_q[`MCL_W_COEF][2 * k]; // R7 R8 R9 R10 R11 R12
    assign coef_negative[k] = act_q[`MCL_W_COEF][2 * k + 1]; // R7 R8 R9 R10 R11 R12
  end

  assign lk.spi_en = cfg_ready && !sel_s2_q; // R14 R15
  assign lk.ss_pol = spi_ss_active_high;
  assign lk.smp_inv = spi_sample_falling;
  assign lk.tx_word = tx_q;
  assign i2c_addr_match = match_q;
  assign i2c_hs_entry = hs_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic wr_ok;
  assign wr_ok = cmd_evt && cfg_ready && is_wr && wr_idx < `MCL_WORD_LIMIT
               && !wr_q[page_q][wr_idx[1:0]];
  mcl_word_t cfg_used;
  assign cfg_used = cmd_data & `MCL_IFCFG_USED;

  sequence s_cfg_write;
    wr_ok && wr_idx == 8'h02;
  endsequence

  sequence s_coef_write;
    wr_ok && wr_idx == 8'h03;
  endsequence

  chk_ident_low_write: assert property ( // R1
    wr_ok && wr_idx == 8'h00 |=> customer_ident[15:0] == $past(cmd_data))
    else $error("customer ident low half not taken from word 00");
  chk_slave_addr_field: assert property ( // R2
    s_cfg_write |=> i2c_slave_addr == $past(cmd_data[6:0]))
    else $error("slave address not bits 6:0 of word 02");
  chk_hs_code_entry: assert property ( // R3
    i2c_addr_vld && sel_s2_q && cfg_ready && addr_hs |=> i2c_hs_entry && !i2c_addr_match)
    else $error("high-speed code not treated as entry code");
  chk_select_polarity: assert property ( // R4
    s_cfg_write |=> spi_ss_active_high == $past(cmd_data[9]))
    else $error("select polarity not bit 9 of word 02");
  chk_spi_mode_decode: assert property ( // R5 R6
    s_cfg_write |=> spi_clk_idle_high == $past(cmd_data[11])
      && spi_sample_falling == ($past(cmd_data[11]) ^ $past(cmd_data[10])))
    else $error("clock idle level or sample edge decoded wrongly");
  chk_coef_fields: assert property ( // R7 R8 R9 R10 R11 R12
    s_coef_write |=> coef_msb == {$past(cmd_data[10]), $past(cmd_data[8]),
      $past(cmd_data[6]), $past(cmd_data[4]), $past(cmd_data[2]), $past(cmd_data[0])}
      && coef_negative == {$past(cmd_data[11]), $past(cmd_data[9]),
      $past(cmd_data[7]), $past(cmd_data[5]), $past(cmd_data[3]), $past(cmd_data[1])})
    else $error("coefficient msb or sign taken from wrong bit");
  chk_write_once_page: assert property ( // R13
    cmd_evt && cfg_ready && is_wr && wr_idx < `MCL_WORD_LIMIT
      && wr_q[page_q][wr_idx[1:0]] |=> rej_q && $stable(customer_ident)
      && $stable(i2c_slave_addr) && $stable(coef_msb))
    else $error("second write to a word in one page was not rejected");
  chk_spi_gate_sel: assert property ( // R14
    sel_s2_q |-> !lk.spi_en)
    else $error("spi enabled while two-wire selected");
  chk_load_before_run: assert property ( // R15
    $fell(cfg_ready) |-> ##4 cfg_ready ##0 $past(!cfg_ready, 1))
    else $error("loader did not finish in four cycles");
  chk_reserved_ignored: assert property ( // R16
    s_cfg_write ##0 cmd_data != cfg_used |=> i2c_slave_addr == $past(cfg_used[6:0])
      && spi_ss_active_high == $past(cfg_used[9])
      && spi_clk_idle_high == $past(cfg_used[11])
      && spi_sample_falling == ($past(cfg_used[11]) ^ $past(cfg_used[10])))
    else $error("reserved bits of word 02 changed the decode");
endmodule
`default_nettype wire

// file: mcl_spi_host.sv
// Purpose: calibration host model driving three-byte serial frames
// Assumes: bench sets clock mode and select polarity between frames
// Notes: clock stands at its idle level outside frames
`timescale 1ns/1ps
`default_nettype none
module mcl_spi_host (
  // serial pins
  output logic link_clk,
  output logic spi_ss,
  output logic spi_mosi,
  input wire logic spi_miso,
  // frame setup
  input wire logic [1:0] mode,
  input wire logic ss_high
);
  initial begin
    link_clk = 1'b0;
    spi_ss = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic set_idle();
    link_clk = mode[1];
    spi_ss = ~ss_high;
  endtask
  // codes 01 and 11 sample on the second edge of a bit, so data moves on the first
  task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
    logic late;
    late = mode[0];
    rx = 24'h000000;
    set_idle();
    #3;
    spi_ss = ss_high;
    for (int i = 23; i >= 0; i--) begin
      if (!late) spi_mosi = tx[i];
      #3;
      link_clk = ~link_clk;
      if (late) spi_mosi = tx[i];
      else rx[i] = spi_miso;
      #3;
      link_clk = ~link_clk;
      if (late) rx[i] = spi_miso;
    end
    #3;
    spi_ss = ~ss_high;
    // a released line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench for the configuration word loader
// Assumes: host model drives the serial pins, the bench drives the rest
// Notes: word 02 is writable once per page, so each clock mode gets a page
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end \
end
module testbench;
  import mcl_pkg::*;
  logic sys_clk, rst_n, if_sel, i2c_addr_vld, link_clk, spi_ss, spi_mosi, spi_miso;
  logic spi_miso_oe, i2c_addr_match, i2c_hs_entry, cfg_ready, spi_ss_active_high;
  logic spi_clk_idle_high, spi_sample_falling, ss_high, oe_seen, rej;
  logic [1:0] page_index, mode, page;
  logic [6:0] i2c_addr_rx, i2c_slave_addr;
  logic [31:0] customer_ident;
  logic [5:0] coef_msb, coef_negative;
  logic [23:0] pend, rx;
  logic [3:0] wr;
  mcl_word_t words [4];
  int miscompares, checks_done, seed;

  mcl_config_loader uut (.sys_clk, .rst_n, .link_clk, .spi_ss, .spi_mosi, .spi_miso,
    .spi_miso_oe, .if_sel, .i2c_addr_vld, .i2c_addr_rx, .i2c_addr_match, .i2c_hs_entry,
    .cfg_ready, .page_index, .customer_ident, .i2c_slave_addr, .spi_ss_active_high,
    .spi_clk_idle_high, .spi_sample_falling, .coef_msb, .coef_negative);
  mcl_spi_host host (.link_clk, .spi_ss, .spi_mosi, .spi_miso, .mode, .ss_high);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge spi_miso_oe) oe_seen = 1'b1;

  function automatic logic [5:0] pick(input mcl_word_t w, input int s);
    for (int i = 0; i < 6; i++) pick[i] = w[2 * i + s];
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_dec();
    `CHECK("ident", {words[1], words[0]}, customer_ident)
    `CHECK("addr", words[2][6:0], i2c_slave_addr)
    `CHECK("sspol", words[2][9], spi_ss_active_high)
    `CHECK("idle", words[2][11], spi_clk_idle_high)
    `CHECK("fall", words[2][11] ^ words[2][10], spi_sample_falling)
    `CHECK("msb", pick(words[3], 0), coef_msb)
    `CHECK("neg", pick(words[3], 1), coef_negative)
    `CHECK("page", page, page_index)
  endtask

  // the reply to each command is seen in the following frame
  task automatic send(input logic [7:0] c, input mcl_word_t d);
    mcl_word_t rd;
    logic bsy;
    @(negedge sys_clk);
    oe_seen = 1'b0;
    host.frame({c, d}, rx);
    `CHECK("reply", pend, rx)
    `CHECK("oe", 1'b1, oe_seen)
    rd = 16'h0000;
    bsy = 1'b0;
    if (c >= 8'h40 && c <= 8'h43) begin
      if (wr[c[1:0]]) rej = 1'b1;
      else begin
        words[c[1:0]] = d;
        wr[c[1:0]] = 1'b1;
        rej = 1'b0;
      end
    end else if (c == 8'h5E) begin
      if (page == 2'h3) rej = 1'b1;
      else begin
        page++;
        words = '{default: 16'h0000};
        wr = 4'h0;
        rej = 1'b0;
        // the new page is still loading when its reply is formed
        bsy = 1'b1;
      end
    end else if (c <= 8'h03) rd = words[c[1:0]];
    pend = {2'h1, bsy, 3'h0, rej, 1'b0, rd};
    repeat (10) @(negedge sys_clk);
    mode = words[2][11:10];
    ss_high = words[2][9];
    host.set_idle();
  endtask

  task automatic i2c_try(input logic [6:0] a, input logic m, input logic h);
    @(negedge sys_clk);
    i2c_addr_vld = 1'b1;
    i2c_addr_rx = a;
    @(negedge sys_clk);
    i2c_addr_vld = 1'b0;
    `CHECK("match", m, i2c_addr_match)
    `CHECK("hs", h, i2c_hs_entry)
  endtask

  task automatic i2c_check();
    logic [6:0] a, mis;
    a = words[2][6:0];
    mis = a ^ 7'h40;
    if (mis[6:2] == 5'h01) mis = 7'h10;
    i2c_try(a, 1'b0, 1'b0);
    if_sel = 1'b1;
    repeat (4) @(negedge sys_clk);
    oe_seen = 1'b0;
    host.frame(24'h420000, rx);
    `CHECK("oe", 1'b0, oe_seen)
    i2c_try(a, 1'b1, 1'b0);
    i2c_try(mis, 1'b0, 1'b0);
    for (int i = 4; i < 8; i++) i2c_try(7'(i), 1'b0, 1'b1);
    if_sel = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end

  initial begin
    mcl_word_t cfg;
    rst_n = 1'b0;
    if_sel = 1'b0;
    i2c_addr_vld = 1'b0;
    i2c_addr_rx = 7'h00;
    mode = 2'h0;
    ss_high = 1'b0;
    oe_seen = 1'b0;
    miscompares = 0;
    checks_done = 0;
    seed = 70139;
    words = '{default: 16'h0000};
    wr = 4'h0;
    rej = 1'b0;
    page = 2'h0;
    // no command has run yet, so the first reply is the cleared word
    pend = 24'h000000;
    repeat (3) @(negedge sys_clk);
    `CHECK("ready", 1'b0, cfg_ready)
    chk_dec();
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHECK("ready", 1'b0, cfg_ready)
    @(negedge sys_clk);
    `CHECK("ready", 1'b1, cfg_ready)
    repeat (4) @(negedge sys_clk);
    $display("reset test done");
    for (int p = 0; p < 4; p++) begin
      cfg = 16'($random(seed));
      cfg[11:10] = 2'(p);
      if (cfg[6:2] == 5'h01) cfg[2] = 1'b0;
      send(8'h42, cfg);
      chk_dec();
      send(8'h40, 16'($random(seed)));
      send(8'h41, 16'($random(seed)));
      send(8'h43, 16'($random(seed)));
      send(8'h02, 16'h0000);
      send(8'h03, 16'h0000);
      send(8'h42, ~cfg);
      send(8'h01, 16'h0000);
      chk_dec();
      i2c_check();
      send(8'h5E, 16'h0000);
      $display("page %0d test done", p);
    end
    send(8'h00, 16'h0000);
    chk_dec();
    // a reset in mid-run clears every page, since the store is held in flops
    rst_n = 1'b0;
    @(negedge sys_clk);
    `CHECK("ready", 1'b0, cfg_ready)
    rst_n = 1'b1;
    words = '{default: 16'h0000};
    wr = 4'h0;
    rej = 1'b0;
    page = 2'h0;
    pend = 24'h000000;
    mode = 2'h0;
    ss_high = 1'b0;
    host.set_idle();
    repeat (6) @(negedge sys_clk);
    chk_dec();
    send(8'h44, 16'($random(seed)));
    send(8'h10, 16'h0000);
    send(8'h00, 16'h0000);
    $display("mid-run reset test done");
    close_out();
  end
endmodule
`default_nettype wire
